// ==== fic_consts.svh ====
// Contract
// - Disclosed flash fault: error frame with address
// - Hidden flash fault: address field holds unused code
// - Start byte opens frame, others ignored
// - Missing end byte gives packet error
// - Checksum mismatch gives checksum error
// - Bad length bytes give packet error
// - Rejection: no processing, back to wait
// - Disallowed lifecycle state: acceptance error
// - Source field mismatch: parameter error
// - Destination not secure-development: parameter error
// - Initialization disabled: protection error
// - Any zero protect vector bit: protection error
// - Programming disable bit zero: protection error
// - Protection erase fault: flash error, wait
// - User erase fault: flash error with address
// - Data or config erase fault: flash error
// - Boundary or key erase fault: flash error
// - Lifecycle update fault: flash error, keep serving
// - Invalid lifecycle state: hardware error, then silent
// - Full success: OK reply, then silent
// - Report only highest priority error
// - Lifecycle codes 02, 03, 04
`ifndef FIC_CONSTS_SVH
`define FIC_CONSTS_SVH
// Frame bytes
`define FIC_SOH         8'h01
`define FIC_ETX         8'h03
`define FIC_RSP_START   8'h81
`define FIC_CMD_INIT    8'h50
`define FIC_CMD_LEN     16'h0003
`define FIC_RSP_LEN     8'h0A
`define FIC_RES_OK      8'h50
`define FIC_RES_ERR     8'hD0
`define FIC_UNUSED      32'hFFFFFFFF
`define FIC_RSP_LAST    4'hE
// Status codes
`define FIC_ST_OK       8'h00
`define FIC_ST_PACKET   8'hC1
`define FIC_ST_CHKSUM   8'hC2
`define FIC_ST_ACCEPT   8'hC3
`define FIC_ST_PARAM    8'hC4
`define FIC_ST_PROTECT  8'hC5
`define FIC_ST_FLASH    8'hE5
`define FIC_ST_HW       8'hC6
// Lifecycle codes
`define FIC_LC_SSD      8'h02
`define FIC_LC_NONSECURE_DEVELOPMENT_STATE   8'h03
`define FIC_LC_DPL      8'h04
// Erase steps, lifecycle update last
`define FIC_STEP_LAST   3'h5
// Register offsets and reset values
`define FIC_REG_CTRL    4'h0
`define FIC_REG_ACCEPT  4'h4
`define FIC_REG_STATUS  4'h8
`define FIC_CTRL_RST    1'h0
`define FIC_ACCEPT_RST  3'h7
`endif

// ==== fic_pkg.sv ====
package fic_pkg;
  // Receive, check, erase and reply phases
  typedef enum logic [9:0] {
    FIC_IDLE  = 10'h001,
    FIC_LNH   = 10'h002,
    FIC_LNL   = 10'h004,
    FIC_BODY  = 10'h008,
    FIC_SUM   = 10'h010,
    FIC_END   = 10'h020,
    FIC_EVAL  = 10'h040,
    FIC_ERASE = 10'h080,
    FIC_TX    = 10'h100,
    FIC_HALT  = 10'h200
  } fic_state_t;
  // Fields of one reply frame
  typedef struct packed {
    logic [7:0]  res;
    logic [7:0]  sts;
    logic [31:0] st2;
    logic [31:0] adr;
  } fic_rsp_t;
endpackage

// ==== fic_flash_init.sv ====
`timescale 1ns/1ps
`include "fic_consts.svh"
module fic_flash_init #(
  parameter int PV_W = 140
) (
  input  wire logic            mclk_in,
  input  wire logic            rst_n_in,
  input  wire logic            ce_in,
  input  wire logic [3:0]      avs_address_in,
  input  wire logic            avs_read_in,
  input  wire logic            avs_write_in,
  input  wire logic [31:0]     avs_writedata_in,
  input  wire logic [3:0]      avs_byteenable_in,
  output logic      [31:0]     avs_readdata_out,
  output logic                 avs_waitrequest_out,
  input  wire logic            rx_valid_in,
  input  wire logic [7:0]      rx_data_in,
  output logic                 tx_valid_out,
  output logic      [7:0]      tx_data_out,
  input  wire logic            tx_ready_in,
  input  wire logic [7:0]      lifecycle_state_in,
  input  wire logic [PV_W-1:0] permanent_protect_vector_in,
  input  wire logic [PV_W-1:0] permanent_protect_vector_secure_in,
  input  wire logic            programming_disable_bit_in,
  output logic                 flash_req_out,
  output logic      [2:0]      flash_step_out,
  input  wire logic            flash_done_in,
  input  wire logic            flash_err_in,
  input  wire logic [31:0]     flash_status_word_in,
  input  wire logic [31:0]     flash_fail_addr_in,
  input  wire logic            flash_disclosed_in,
  output logic                 halted_out
);

  // Vector width must be usable
  // A zero width would leave the check empty
  if (PV_W < 1) begin : g_chk
    $error("PV_W must be at least 1");
  end

  // Sequencer and the reply it is building
  fic_pkg::fic_state_t state_q;        // Main sequencer
  fic_pkg::fic_rsp_t   rsp_q;          // Reply being sent

  // Frame fields as they arrive
  logic [7:0]          lnh_q;          // Length high
  logic [7:0]          lnl_q;          // Length low
  logic [7:0]          cnt_q;          // Body bytes seen
  logic [7:0]          cmd_q;          // Command code
  logic [7:0]          src_q;          // Source lifecycle field
  logic [7:0]          dst_q;          // Destination lifecycle field
  logic [7:0]          sum_q;          // Running checksum
  logic                etx_ok_q;       // End byte matched

  // Erase and reply progress
  logic [2:0]          step_q;         // Erase step
  logic [3:0]          idx_q;          // Reply byte index
  logic [7:0]          txd_q;          // Reply byte on the wire
  logic                halt_next_q;    // Go silent after reply

  // Software settings and bus answer
  logic                init_dis_q;     // Initialization disabled
  logic [2:0]          accept_q;       // Allowed states SECURE_DEVELOPMENT_STATE,NONSECURE_DEVELOPMENT_STATE,DEPLOYED_STATE
  logic [7:0]          last_sts_q;     // Last reported status
  logic                ack_q;          // Bus answer phase
  logic [31:0]         rdata_q;        // Bus read data

  // Bus decode. Every writable field sits in byte lane
  // zero, so that lane alone gates a write; the
  // status word is read-only and unmapped
  // offsets read as zero.
  wire        bus_req   = avs_read_in | avs_write_in;
  wire        sel_ctrl  = avs_address_in == `FIC_REG_CTRL;
  wire        sel_acc   = avs_address_in == `FIC_REG_ACCEPT;
  wire        sel_stat  = avs_address_in == `FIC_REG_STATUS;
  wire        wr_commit = avs_write_in & ack_q & avs_byteenable_in[0];
  wire [31:0] rd_mux    = sel_ctrl ? {31'h0, init_dis_q} :
                          sel_acc  ? {29'h0, accept_q} :
                          sel_stat ? {19'h0, step_q, state_q[9],
                                      ~state_q[0], last_sts_q} :
                          32'h0;

  // Frame byte events. The link has no ready,
  // so a byte that arrives while the block is
  // busy is lost; the host must wait for the
  // reply before it sends again.
  wire       rx_take  = rx_valid_in & ce_in;
  wire [7:0] sum_add  = sum_q + rx_data_in;
  wire       body_end = (cnt_q + 8'h01) == lnl_q;

  // Check chain, highest priority first.
  // All checks are flat terms on registered
  // fields and inputs, so the verdict settles within
  // the one evaluation cycle.
  wire lc_ssd    = lifecycle_state_in == `FIC_LC_SSD;
  wire lc_nsd    = lifecycle_state_in == `FIC_LC_NONSECURE_DEVELOPMENT_STATE;
  wire lc_dpl    = lifecycle_state_in == `FIC_LC_DPL;
  wire lc_valid  = lc_ssd | lc_nsd | lc_dpl;
  wire etx_bad   = ~etx_ok_q;
  wire sum_bad   = sum_q != 8'h00;
  wire fmt_bad   = (lnh_q != 8'h00) | (lnl_q == 8'h00);
  wire len_bad   = {lnh_q, lnl_q} != `FIC_CMD_LEN;
  wire not_ours  = cmd_q != `FIC_CMD_INIT;
  wire acc_bad   = ~((lc_ssd & accept_q[0]) | (lc_nsd & accept_q[1])
                   | (lc_dpl & accept_q[2]));
  wire src_bad   = src_q != lifecycle_state_in;
  wire dst_bad   = dst_q != `FIC_LC_SSD;
  wire prot_bad  = init_dis_q
                 | ~(&permanent_protect_vector_in)
                 | ~(&permanent_protect_vector_secure_in)
                 | ~programming_disable_bit_in;

  // Framing faults win over a foreign command,
  // which is otherwise dropped without a reply
  wire frame_bad = etx_bad | sum_bad | fmt_bad | len_bad;
  wire eval_err  = frame_bad | (~not_ours & (acc_bad | src_bad | dst_bad | prot_bad));

  // First failing check picks the status
  wire [7:0] eval_sts = etx_bad  ? `FIC_ST_PACKET :
                        sum_bad  ? `FIC_ST_CHKSUM :
                        fmt_bad  ? `FIC_ST_PACKET :
                        len_bad  ? `FIC_ST_PACKET :
                        acc_bad  ? `FIC_ST_ACCEPT :
                        src_bad  ? `FIC_ST_PARAM :
                        dst_bad  ? `FIC_ST_PARAM :
                                   `FIC_ST_PROTECT;

  // Flash fault report, address only where disclosed.
  // Fault inputs are sampled with the faulting
  // done pulse only and need not hold after it.
  wire [31:0] fault_adr = flash_disclosed_in ? flash_fail_addr_in
                                             : `FIC_UNUSED;
  wire        step_ok   = flash_done_in & ~flash_err_in;
  wire        step_bad  = flash_done_in & flash_err_in;

  // Reply checksum, two's complement of the bytes after the start.
  // Worked from the held reply fields, so it is
  // ready long before its slot in the stream.
  wire [7:0] rsp_sum = 8'h00 - (`FIC_RSP_LEN + rsp_q.res + rsp_q.sts
                     + rsp_q.st2[31:24] + rsp_q.st2[23:16]
                     + rsp_q.st2[15:8] + rsp_q.st2[7:0]
                     + rsp_q.adr[31:24] + rsp_q.adr[23:16]
                     + rsp_q.adr[15:8] + rsp_q.adr[7:0]);

  // Reply byte selector, most significant byte first
  // Index 14 and beyond give the end byte
  function automatic logic [7:0] rsp_byte(input logic [3:0] i,
                                          input fic_pkg::fic_rsp_t r,
                                          input logic [7:0] s);
    logic [7:0] b;
    b = 8'h00;
    unique case (i)
      4'h0:    b = `FIC_RSP_START;
      4'h1:    b = 8'h00;
      4'h2:    b = `FIC_RSP_LEN;
      4'h3:    b = r.res;
      4'h4:    b = r.sts;
      4'h5:    b = r.st2[31:24];
      4'h6:    b = r.st2[23:16];
      4'h7:    b = r.st2[15:8];
      4'h8:    b = r.st2[7:0];
      4'h9:    b = r.adr[31:24];
      4'hA:    b = r.adr[23:16];
      4'hB:    b = r.adr[15:8];
      4'hC:    b = r.adr[7:0];
      4'hD:    b = s;
      default: b = `FIC_ETX;
    endcase
    return b;
  endfunction

  // A reply byte leaves on valid and ready
  wire       tx_fire = tx_valid_out & tx_ready_in & ce_in;
  wire [3:0] idx_nx  = idx_q + 4'h1;

  // Bus slave: one wait cycle, then answer.
  // The fixed wait costs a cycle per access but
  // lets read data come straight from a flop.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ack_q      <= 1'b0;
      rdata_q    <= 32'h0;
      init_dis_q <= `FIC_CTRL_RST;
      accept_q   <= `FIC_ACCEPT_RST;
    end else if (ce_in) begin
      ack_q <= bus_req & ~ack_q;
      // Latch read data ahead of the answer edge
      if (avs_read_in & ~ack_q) begin
        rdata_q <= rd_mux;
      end
      // Writes land only on the answer edge
      if (wr_commit & sel_ctrl) begin
        init_dis_q <= avs_writedata_in[0];
      end
      if (wr_commit & sel_acc) begin
        accept_q <= avs_writedata_in[2:0];
      end
    end
  end

  // Wait only in the first cycle of a request
  assign avs_waitrequest_out = bus_req & ~ack_q;
  assign avs_readdata_out    = rdata_q;

  // Receive side: header, length, body, checksum, end byte.
  // Then check, erase, reply and, after a final
  // answer, stay silent until reset.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_q     <= fic_pkg::FIC_IDLE;
      lnh_q       <= 8'h00;
      lnl_q       <= 8'h00;
      cnt_q       <= 8'h00;
      cmd_q       <= 8'h00;
      src_q       <= 8'h00;
      dst_q       <= 8'h00;
      sum_q       <= 8'h00;
      etx_ok_q    <= 1'b0;
      step_q      <= 3'h0;
      idx_q       <= 4'h0;
      txd_q       <= 8'h00;
      halt_next_q <= 1'b0;
      last_sts_q  <= `FIC_ST_OK;
      rsp_q       <= '0;
    end else if (ce_in) begin
      unique case (state_q)
        // Hunt for the start byte, drop everything else
        // A new frame clears sum, count and command
        fic_pkg::FIC_IDLE: begin
          if (rx_take && rx_data_in == `FIC_SOH) begin
            sum_q   <= 8'h00;
            cnt_q   <= 8'h00;
            cmd_q   <= 8'h00;
            state_q <= fic_pkg::FIC_LNH;
          end
        end

        // Length high byte, kept for the format check
        fic_pkg::FIC_LNH: begin
          if (rx_take) begin
            lnh_q   <= rx_data_in;
            sum_q   <= sum_add;
            state_q <= fic_pkg::FIC_LNL;
          end
        end

        // Empty body skips straight to the checksum
        fic_pkg::FIC_LNL: begin
          if (rx_take) begin
            lnl_q   <= rx_data_in;
            sum_q   <= sum_add;
            state_q <= (rx_data_in == 8'h00) ? fic_pkg::FIC_SUM
                                             : fic_pkg::FIC_BODY;
          end
        end

        // Keep the first three body bytes, count the rest
        // Only the low length byte sets the count
        fic_pkg::FIC_BODY: begin
          if (rx_take) begin
            sum_q <= sum_add;
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == 8'h00) begin
              cmd_q <= rx_data_in;
            end
            if (cnt_q == 8'h01) begin
              src_q <= rx_data_in;
            end
            if (cnt_q == 8'h02) begin
              dst_q <= rx_data_in;
            end
            if (body_end) begin
              state_q <= fic_pkg::FIC_SUM;
            end
          end
        end

        // Checksum byte joins the running sum
        fic_pkg::FIC_SUM: begin
          if (rx_take) begin
            sum_q   <= sum_add;
            state_q <= fic_pkg::FIC_END;
          end
        end

        // Last byte must be the end byte
        fic_pkg::FIC_END: begin
          if (rx_take) begin
            etx_ok_q <= rx_data_in == `FIC_ETX;
            state_q  <= fic_pkg::FIC_EVAL;
          end
        end

        // Any rejection replies without touching flash, except a clean foreign command, which goes back to idle
        fic_pkg::FIC_EVAL: begin
          rsp_q.res   <= `FIC_RES_ERR;
          rsp_q.st2   <= `FIC_UNUSED;
          rsp_q.adr   <= `FIC_UNUSED;
          halt_next_q <= 1'b0;
          step_q      <= 3'h0;
          if (eval_err) begin
            rsp_q.sts  <= eval_sts;
            last_sts_q <= eval_sts;
            idx_q      <= 4'h0;
            txd_q      <= `FIC_RSP_START;
            state_q    <= fic_pkg::FIC_TX;
          end else if (not_ours) begin
            state_q <= fic_pkg::FIC_IDLE;
          end else begin
            state_q <= fic_pkg::FIC_ERASE;
          end
        end

        // Walk the erase steps, stop at the first fault
        // Request and step stand until done
        fic_pkg::FIC_ERASE: begin
          if (step_bad) begin
            rsp_q.sts  <= `FIC_ST_FLASH;
            rsp_q.st2  <= flash_status_word_in;
            rsp_q.adr  <= fault_adr;
            last_sts_q <= `FIC_ST_FLASH;
            idx_q      <= 4'h0;
            txd_q      <= `FIC_RSP_START;
            state_q    <= fic_pkg::FIC_TX;
          end else if (step_ok && step_q != `FIC_STEP_LAST) begin
            step_q <= step_q + 3'h1;
          end else if (step_ok) begin
            // Stored state must be sane after the update
            // A code other than 02, 03 or 04 means corrupt storage
            halt_next_q <= 1'b1;
            rsp_q.res   <= lc_valid ? `FIC_RES_OK : `FIC_RES_ERR;
            rsp_q.sts   <= lc_valid ? `FIC_ST_OK : `FIC_ST_HW;
            last_sts_q  <= lc_valid ? `FIC_ST_OK : `FIC_ST_HW;
            idx_q       <= 4'h0;
            txd_q       <= `FIC_RSP_START;
            state_q     <= fic_pkg::FIC_TX;
          end
        end

        // Stream the reply, data held stable until taken
        fic_pkg::FIC_TX: begin
          if (tx_fire) begin
            idx_q <= idx_nx;
            txd_q <= (idx_nx == 4'hD) ? rsp_sum : rsp_byte(idx_nx, rsp_q, rsp_sum);
            if (idx_q == `FIC_RSP_LAST) begin
              state_q <= halt_next_q ? fic_pkg::FIC_HALT
                                     : fic_pkg::FIC_IDLE;
            end
          end
        end

        // Silent until reset
        fic_pkg::FIC_HALT: begin
          state_q <= fic_pkg::FIC_HALT;
        end

        // Lost one-hot code falls back to idle
        default: begin
          state_q <= fic_pkg::FIC_IDLE;
        end
      endcase
    end
  end

  // Outputs straight from state and flops.
  // Valid and request are state decodes, so
  // they drop at the edge the state leaves.
  assign tx_valid_out   = state_q == fic_pkg::FIC_TX;
  assign tx_data_out    = txd_q;
  assign flash_req_out  = state_q == fic_pkg::FIC_ERASE;
  assign flash_step_out = step_q;
  assign halted_out     = state_q == fic_pkg::FIC_HALT;

endmodule // fic_flash_init

// ==== fic_chk_assertions.sv ====
`timescale 1ns/1ps
module fic_chk_assertions (
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic       tx_valid_out,
  input wire logic [7:0] tx_data_out,
  input wire logic       tx_ready_in,
  input wire logic       flash_req_out,
  input wire logic [2:0] flash_step_out,
  input wire logic       flash_done_in,
  input wire logic       flash_err_in,
  input wire logic       halted_out
);
  // One domain: clock and reset stated once
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  wire ok_w  = flash_req_out && flash_done_in && !flash_err_in; // Step passed
  wire bad_w = flash_req_out && flash_done_in && flash_err_in;  // Step faulted
  // Halt is final until reset
  property p_stay; halted_out |=> halted_out; endproperty
  a_stay: assert property (p_stay) else $error("halt dropped");
  property p_mute; halted_out |-> !tx_valid_out && !flash_req_out; endproperty
  a_mute: assert property (p_mute) else $error("halted but active");
  // Erase opens with the protection step
  property p_first; $rose(flash_req_out) |-> flash_step_out == 3'h0; endproperty
  a_first: assert property (p_first) else $error("erase not from step 0");
  // Steps advance one at a time
  property p_next;
    ok_w && flash_step_out != 3'h5 |=>
      flash_req_out && flash_step_out == $past(flash_step_out) + 3'h1;
  endproperty
  a_next: assert property (p_next) else $error("step order broken");
  // A fault stops erasing and starts the reply at once
  property p_abort; bad_w |=> !flash_req_out && tx_valid_out && tx_data_out == 8'h81; endproperty
  a_abort: assert property (p_abort) else $error("fault not answered");
  property p_done; ok_w && flash_step_out == 3'h5 |=> !flash_req_out && tx_valid_out; endproperty
  a_done: assert property (p_done) else $error("no reply after last step");
  // Reply byte held while the host stalls
  property p_hold; tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out); endproperty
  a_hold: assert property (p_hold) else $error("reply byte lost");
  property p_start; $rose(tx_valid_out) |-> tx_data_out == 8'h81; endproperty
  a_start: assert property (p_start) else $error("reply start wrong");
  c_halt: cover property ($rose(halted_out));
  c_fault: cover property (bad_w);
  c_stall: cover property (tx_valid_out && !tx_ready_in);
endmodule // fic_chk_assertions
bind fic_flash_init fic_chk_assertions i_fic_chk_assertions (.mclk_in, .rst_n_in,
  .tx_valid_out, .tx_data_out, .tx_ready_in, .flash_req_out, .flash_step_out,
  .flash_done_in, .flash_err_in, .halted_out);

// ==== fic_host_model.sv ====
`timescale 1ns/1ps
module fic_host_model (
  input  wire logic       mclk_in,
  input  wire logic       slow_in,
  output logic            rx_valid_out,
  output logic      [7:0] rx_data_out,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            tx_ready_out
);
  logic [7:0] send_q [$];      // Bytes still to go out
  logic [7:0] got_q [$];       // Reply bytes taken
  logic [7:0] last_q = 8'h00;  // Last byte on the line
  logic       tog_q = 1'h0;    // Halves accept rate when slow
  initial begin
    rx_valid_out = 1'h0;
    rx_data_out = 8'hFF;
    tx_ready_out = 1'h0;
  end
  // One byte per cycle out; reply byte taken on valid and ready
  always @(posedge mclk_in) begin
    tog_q <= ~tog_q;
    tx_ready_out <= !slow_in || tog_q;  // Slow host stalls every other cycle
    if (tx_valid_in && tx_ready_out) begin
      got_q.push_back(tx_data_in);
    end
    if (send_q.size() > 0) begin
      last_q = send_q.pop_front();
      rx_valid_out <= 1'h1;
      rx_data_out <= last_q;
    end else begin
      rx_valid_out <= 1'h0;
      rx_data_out <= ~last_q;  // Idle line shows no stale byte
    end
  end
endmodule // fic_host_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "fic_consts.svh"
module tb_top;
  typedef logic [7:0] fic_bq_t [$];               // Bytes of one frame
  logic           mclk_in = 1'h0;                 // 25 MHz clock
  logic           rst_n = 1'h0, rd = 1'h0, wr = 1'h0;
  logic [3:0]     addr = 4'h0;                    // Avalon request
  logic [31:0]    wdata = 32'h0, rdata, rdo;
  logic           wait_req, rxv, txv, txr, fq, halted;
  logic [7:0]     rxd, txd, steps = 8'h0;         // Steps: done pulses seen
  logic [7:0]     lc = 8'h02;                     // Stored lifecycle code
  logic [139:0]   pv = {140{1'h1}}, pvs = {140{1'h1}};
  logic           pdis = 1'h1, fdisc = 1'h1, done = 1'h0, ferr = 1'h0;
  logic           slow = 1'h0, hw = 1'h0;
  logic [2:0]     fstep, fail = 3'h7;             // 7: no step faults
  logic [1:0]     fcnt = 2'h0;
  int             fails = 0, comparisons = 0, cycles = 0;
  initial begin
    forever #20 mclk_in = ~mclk_in;
  end
  fic_flash_init i_fic_flash_init (
    .mclk_in(mclk_in), .rst_n_in(rst_n), .ce_in(1'h1), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdo), .avs_waitrequest_out(wait_req),
    .rx_valid_in(rxv), .rx_data_in(rxd), .tx_valid_out(txv), .tx_data_out(txd),
    .tx_ready_in(txr), .lifecycle_state_in(lc), .permanent_protect_vector_in(pv),
    .permanent_protect_vector_secure_in(pvs), .programming_disable_bit_in(pdis),
    .flash_req_out(fq), .flash_step_out(fstep), .flash_done_in(done),
    .flash_err_in(ferr), .flash_status_word_in(32'h0120A000),
    .flash_fail_addr_in(32'h00004000), .flash_disclosed_in(fdisc), .halted_out(halted));
  fic_host_model i_fic_host_model (.mclk_in(mclk_in), .slow_in(slow), .rx_valid_out(rxv),
    .rx_data_out(rxd), .tx_valid_in(txv), .tx_data_in(txd), .tx_ready_out(txr));
  // Flash stand-in: each step ends three cycles after it is raised
  always @(posedge mclk_in) begin
    fcnt <= (done || !fq) ? 2'h0 : fcnt + 2'h1;
    done <= fq && !done && fcnt == 2'h2;
    ferr <= fstep == fail;
    steps <= done ? steps + 8'h1 : steps;
    if (hw && fq && fstep == 3'h5) begin
      lc <= 8'h07;  // Stored state corrupted late
    end
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic check(input string nm, input logic [119:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do @(posedge mclk_in); while (wait_req !== 1'h0);
    rdata = rdo;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask
  // Command frame as the host builds it
  function automatic fic_bq_t mk(input logic [7:0] s, d, adj, e);
    logic [7:0] sm;
    sm = 8'h00 - 8'h03 - 8'h50 - s - d + adj;
    return '{8'h01, 8'h00, 8'h03, 8'h50, s, d, sm, e};
  endfunction
  // Expected reply; the sum zeroes all bytes from after the start byte up to the sum itself
  function automatic logic [119:0] rep(input logic [7:0] r, s, input logic [31:0] w, a);
    logic [7:0] sm;
    sm = 8'h00 - 8'h0A - r - s;
    for (int i = 0; i < 4; i++)
      sm = sm - w[8*i+:8] - a[8*i+:8];
    return {8'h81, 8'h00, 8'h0A, r, s, w, a, sm, 8'h03};
  endfunction
  function automatic logic [119:0] err(input logic [7:0] st);
    return rep(`FIC_RES_ERR, st, `FIC_UNUSED, `FIC_UNUSED);
  endfunction
  // Queue a frame and gather a 15-byte answer, or nothing
  task automatic send(input fic_bq_t f, output logic [119:0] got);
    int n;
    n = 0;
    @(negedge mclk_in);
    foreach (f[i]) i_fic_host_model.send_q.push_back(f[i]);
    while (i_fic_host_model.got_q.size() < 15 && n < 300) begin
      @(negedge mclk_in);
      n++;
    end
    got = 120'h0;
    while (i_fic_host_model.got_q.size() > 0)
      got = {got[111:0], i_fic_host_model.got_q.pop_front()};
    repeat (3) @(posedge mclk_in);
  endtask
  task automatic t_regs();
    bus(1'h0, `FIC_REG_CTRL, 32'h0);
    check("ctrl", rdata, 32'h0);
    bus(1'h0, `FIC_REG_ACCEPT, 32'h0);
    check("accept", rdata, 32'h7);
    bus(1'h1, 4'hC, 32'h5);
    bus(1'h0, 4'hC, 32'h0);
    check("unmapped", rdata, 32'h0);
  endtask
  // Noise first, then framing faults, the higher one winning
  task automatic t_frame();
    logic [119:0] g;
    fic_bq_t f;
    f = mk(8'h02, 8'h02, 8'h00, 8'h04);
    f.push_front(8'h55);
    send(f, g);
    check("end byte", g, err(`FIC_ST_PACKET));
    send(mk(8'h02, 8'h03, 8'h01, 8'h03), g);
    check("checksum", g, err(`FIC_ST_CHKSUM));
    send('{8'h01, 8'h01, 8'h03, 8'h50, 8'h02, 8'h02, 8'hA8, 8'h03}, g);
    check("format", g, err(`FIC_ST_PACKET));
    send('{8'h01, 8'h00, 8'h02, 8'h50, 8'h02, 8'hAC, 8'h03}, g);
    check("length", g, err(`FIC_ST_PACKET));
    send('{8'h01, 8'h00, 8'h03, 8'h51, 8'h02, 8'h02, 8'hA8, 8'h03}, g);
    check("other command", g, 120'h0);
  endtask
  task automatic t_param();
    logic [119:0] g;
    bus(1'h1, `FIC_REG_ACCEPT, 32'h6);
    send(mk(8'h02, 8'h03, 8'h00, 8'h03), g);
    check("acceptance", g, err(`FIC_ST_ACCEPT));
    bus(1'h0, `FIC_REG_STATUS, 32'h0);
    check("last status", rdata, 32'h000000C3);
    bus(1'h1, `FIC_REG_ACCEPT, 32'h7);
    send(mk(8'h03, 8'h02, 8'h00, 8'h03), g);
    check("source", g, err(`FIC_ST_PARAM));
    send(mk(8'h02, 8'h04, 8'h00, 8'h03), g);
    check("destination", g, err(`FIC_ST_PARAM));
  endtask
  task automatic t_protect();
    logic [119:0] g;
    bus(1'h1, `FIC_REG_CTRL, 32'h1);
    send(mk(8'h02, 8'h02, 8'h00, 8'h03), g);
    check("disabled", g, err(`FIC_ST_PROTECT));
    bus(1'h1, `FIC_REG_CTRL, 32'h0);
    pv[139] <= 1'h0;
    send(mk(8'h02, 8'h02, 8'h00, 8'h03), g);
    check("vector", g, err(`FIC_ST_PROTECT));
    pv[139] <= 1'h1;
    pvs[0] <= 1'h0;
    send(mk(8'h02, 8'h02, 8'h00, 8'h03), g);
    check("secure vector", g, err(`FIC_ST_PROTECT));
    pvs[0] <= 1'h1;
    pdis <= 1'h0;
    send(mk(8'h02, 8'h02, 8'h00, 8'h03), g);
    check("program bit", g, err(`FIC_ST_PROTECT));
    pdis <= 1'h1;
    check("untouched", steps, 8'h0);
  endtask
  // Fault at each step, slow host; odd steps hide the address
  task automatic t_flash();
    logic [119:0] g;
    slow <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      fail <= 3'(i);
      fdisc <= i[0] == 1'h0;
      send(mk(8'h02, 8'h02, 8'h00, 8'h03), g);
      check("fault", g, rep(`FIC_RES_ERR, `FIC_ST_FLASH, 32'h0120A000,
        fdisc ? 32'h00004000 : `FIC_UNUSED));
    end
    check("steps run", steps, 8'h15);
    check("serving", halted, 1'h0);
  endtask
  task automatic t_hw();
    logic [119:0] g;
    slow <= 1'h0;
    fail <= 3'h7;
    hw <= 1'h1;
    send(mk(8'h02, 8'h02, 8'h00, 8'h03), g);
    check("hardware", g, err(`FIC_ST_HW));
    send(mk(8'h02, 8'h02, 8'h00, 8'h03), g);
    check("silent", g, 120'h0);
    rst_n <= 1'h0;
    hw <= 1'h0;
    lc <= 8'h02;
    repeat (2) @(posedge mclk_in);
    rst_n <= 1'h1;
    @(posedge mclk_in);
    send(mk(8'h02, 8'h02, 8'h00, 8'h03), g);
    check("ok", g, rep(`FIC_RES_OK, `FIC_ST_OK, `FIC_UNUSED, `FIC_UNUSED));
    check("halted", halted, 1'h1);
    bus(1'h0, `FIC_REG_STATUS, 32'h0);
    check("status", rdata, 32'h00001700);
  endtask
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_n <= 1'h1;
    @(posedge mclk_in);
    t_regs();
    t_frame();
    t_param();
    t_protect();
    t_flash();
    t_hw();
    give_verdict();
  end
endmodule // tb_top
